// ==== ltp_load_track.sv ====
// Functional notes
// RL1 - Sample wait-for-interrupt idle level on every clock edge.
// RL2 - Average idle samples over non-overlapping windows into a CPU load index.
// RL3 - Weight each of sixteen load inputs and sum the products.
// RL4 - Total load is CPU load plus weighted extra load.
// RL5 - Exponential moving average filters total load before comparison.
// RL6 - Compare average with upper and lower thresholds; separate flags.
// RL7 - Count consecutive up and down crossings; restart on broken run.
// RL8 - Raise interrupt or DMA event when frequency must change.
// RL9 - Log load history; raise event at log-full intervals.
// RL10 - Wait mode stops core clock; fabric, main PLL, oscillator stay on.
// RL11 - Doze stops core and fabric clocks; main PLL stays on.
// RL12 - Stop disables everything, PLLs, audio osc, peripheral clocks; oscillator optional.
// RL13 - Standby voltage enabled makes stop a retention mode with lowered rail.
// RL14 - Static stop: oscillator and low-frequency reference clock both off.
// RL15 - Software arms wakeup, mode and holdoff before wait-for-interrupt.
// RL16 - Standby voltage bit at zero disables retention behaviour.
// RL17 - Software sets start and masks; later unmasks and sets finished.
// RL18 - Software reads advice and voltage level to decide change.
// RL19 - Software disables automatic voltage compensation before change.
// RL20 - Raise voltage before frequency up; lower frequency before voltage.
// RL21 - Weights, window, coefficient and counter widths are design parameters.
// RL22 - Scaling interrupt holds until masked or update-finished written.
module ltp_load_track
	import ltp_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Load sources
	input wire logic wait_for_irq_idle,
	input wire logic [LTP_NLD-1:0] load_in,
	// Scaling events
	output logic scale_irq,
	output logic scale_dma_req,
	// Power mode control
	input wire logic wfi_enter,
	input wire logic wakeup,
	output ltp_pwr_t pwr
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] thr;
		logic [31:0] cnt_lim;
		logic [LTP_NLD*LTP_WW-1:0] wt;
		logic idle_smp;
		logic [LTP_AVG_SH-1:0] win_cnt;
		logic [LTP_AVG_SH:0] busy_acc;
		logic [LTP_LW-1:0] cpu_load;
		logic [LTP_LW-1:0] total;
		logic [LTP_LW-1:0] ema;
		logic up_cross_flag;
		logic down_cross_flag;
		logic [LTP_CW-1:0] up_cnt;
		logic [LTP_CW-1:0] dn_cnt;
		logic [1:0] advice;
		logic scale_pend;
		logic log_pend;
		logic [2:0] log_wr;
		logic [LTP_LOGD*4-1:0] log_mem;
		ltp_mode_t mode;
		logic [31:0] rdata;
	} ltp_st_t;

	ltp_st_t st_ff;
	ltp_st_t nxt_st;
	logic [LTP_LW-1:0] wsum;
	logic [LTP_LW+1:0] load_sum;
	logic [LTP_LW+LTP_EMA_SH:0] ema_w;
	logic win_end;
	logic wr_en;
	logic rd_en;
	logic [LTP_LW-1:0] up_th;
	logic [LTP_LW-1:0] dn_th;
	logic [LTP_LW-1:0] wt_prod [LTP_NLD];

	////////////////////////////////////////////////////////////////////////////////
	// Per-input weighting; each input contributes its weight when active
	generate
		for (genvar i = 0; i < LTP_NLD; i++) begin : g_wt
			assign wt_prod[i] = load_in[i] ? LTP_LW'(st_ff.wt[i*LTP_WW +: LTP_WW]) : '0; // RL3
		end
	endgenerate

	// Adder tree folded as a loop; width chosen so sixteen full weights never wrap
	always_comb begin
		wsum = '0;
		for (int i = 0; i < LTP_NLD; i++) begin
			wsum = LTP_LW'(wsum + wt_prod[i]); // RL3
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB decode; zero wait state, every access ready at once
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = st_ff.rdata;
	assign win_end = &st_ff.win_cnt;
	assign up_th = st_ff.thr[16 +: LTP_LW];
	assign dn_th = st_ff.thr[0 +: LTP_LW];
	assign load_sum = (LTP_LW+2)'(st_ff.cpu_load) + (LTP_LW+2)'(wsum);
	assign ema_w = (LTP_LW+LTP_EMA_SH+1)'({st_ff.ema, {LTP_EMA_SH{1'b0}}})
		- (LTP_LW+LTP_EMA_SH+1)'(st_ff.ema) + (LTP_LW+LTP_EMA_SH+1)'(st_ff.total);

	// Scaling event outputs; DMA routing chosen by control bit
	assign scale_irq = (st_ff.scale_pend | st_ff.log_pend) & ~st_ff.ctrl[LTP_C_MASK]
		& ~st_ff.ctrl[LTP_C_DMA]; // RL22
	assign scale_dma_req = (st_ff.scale_pend | st_ff.log_pend) & ~st_ff.ctrl[LTP_C_MASK]
		& st_ff.ctrl[LTP_C_DMA]; // RL8

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		// Idle sampled every edge, the only path from the raw pin
		nxt_st.idle_smp = wait_for_irq_idle; // RL1
		if (st_ff.ctrl[LTP_C_EN]) begin
			// Window averaging: busy cycles counted, result scaled to load width
			nxt_st.win_cnt = st_ff.win_cnt + 1'b1; // RL2
			nxt_st.busy_acc = st_ff.busy_acc + {{LTP_AVG_SH{1'b0}}, ~st_ff.idle_smp}; // RL2
			if (win_end) begin
				// Last sample of the window counts before the accumulator restarts
				nxt_st.cpu_load = LTP_LW'({nxt_st.busy_acc, 4'h0}); // RL2
				nxt_st.busy_acc = '0;
				// Total saturates rather than wrapping
				nxt_st.total = load_sum[LTP_LW+1:LTP_LW] != 2'h0 ? '1
					: load_sum[LTP_LW-1:0]; // RL4
				// EMA with alpha of one over 2^shift, updated once per window
				nxt_st.ema = ema_w[LTP_EMA_SH +: LTP_LW]; // RL5
				nxt_st.up_cross_flag = st_ff.ema > up_th; // RL6
				nxt_st.down_cross_flag = st_ff.ema < dn_th; // RL6
				// Consecutive runs; a window without crossing restarts the count
				nxt_st.up_cnt = nxt_st.up_cross_flag ? st_ff.up_cnt + 1'b1 : '0; // RL7
				nxt_st.dn_cnt = nxt_st.down_cross_flag ? st_ff.dn_cnt + 1'b1 : '0; // RL7
				if (nxt_st.up_cnt == st_ff.cnt_lim[8 +: LTP_CW]) begin
					nxt_st.scale_pend = 1'b1; // RL8
					nxt_st.advice = 2'h1;
					nxt_st.up_cnt = '0;
				end
				if (nxt_st.dn_cnt == st_ff.cnt_lim[0 +: LTP_CW]) begin
					nxt_st.scale_pend = 1'b1; // RL8
					nxt_st.advice = 2'h2;
					nxt_st.dn_cnt = '0;
				end
				// History log keeps the top nibble of each average
				nxt_st.log_mem[st_ff.log_wr*4 +: 4] = st_ff.ema[LTP_LW-1 -: 4]; // RL9
				nxt_st.log_wr = st_ff.log_wr + 1'b1; // RL9
				if (&st_ff.log_wr && st_ff.ctrl[LTP_C_LOGIE]) begin
					nxt_st.log_pend = 1'b1; // RL9
				end
			end
		end
		// Register writes; a done clear loses to a same-cycle scaling event with new advice, but always clears a log event
		if (wr_en) begin
			unique case (paddr)
				LTP_CTRL_OFS: begin
					nxt_st.ctrl = pwdata;
					if (pwdata[LTP_C_DONE]) begin
						nxt_st.scale_pend = nxt_st.scale_pend & win_end
							& st_ff.ctrl[LTP_C_EN] & nxt_st.advice != st_ff.advice; // RL22
						nxt_st.log_pend = 1'b0;
						nxt_st.advice = nxt_st.scale_pend ? nxt_st.advice : 2'h0;
					end
				end
				LTP_THR_OFS: nxt_st.thr = pwdata;
				LTP_CNT_OFS: nxt_st.cnt_lim = pwdata;
				default: begin
					for (int i = 0; i < LTP_NLD; i++) begin
						if (paddr == LTP_WT_OFS + 8'(i*4)) begin
							nxt_st.wt[i*LTP_WW +: LTP_WW] = pwdata[LTP_WW-1:0]; // RL21
						end
					end
				end
			endcase
		end
		// Done is a self-clearing strobe; start keeps its written value
		if (!wr_en) begin
			nxt_st.ctrl[LTP_C_DONE] = 1'b0;
		end
		// Power mode sequencing; wait-for-interrupt enters the programmed mode
		if (wakeup) begin
			nxt_st.mode = LTP_RUN;
		end else if (wfi_enter && st_ff.mode == LTP_RUN) begin
			nxt_st.mode = ltp_mode_t'(st_ff.ctrl[LTP_C_LPM +: 2]);
		end
		// Read data captured in setup phase, unmapped addresses read zero
		if (rd_en) begin
			unique case (paddr)
				LTP_CTRL_OFS: nxt_st.rdata = st_ff.ctrl;
				LTP_THR_OFS: nxt_st.rdata = st_ff.thr;
				LTP_CNT_OFS: nxt_st.rdata = st_ff.cnt_lim;
				LTP_STAT_OFS: nxt_st.rdata = {12'h0, st_ff.mode, st_ff.dn_cnt, st_ff.up_cnt,
					st_ff.log_pend, st_ff.scale_pend, st_ff.down_cross_flag,
					st_ff.up_cross_flag, st_ff.advice};
				LTP_LOAD_OFS: nxt_st.rdata = {6'h0, st_ff.ema, 6'h0, st_ff.cpu_load};
				LTP_LOG_OFS: nxt_st.rdata = st_ff.log_mem;
				default: begin
					nxt_st.rdata = 32'h0;
					for (int i = 0; i < LTP_NLD; i++) begin
						if (paddr == LTP_WT_OFS + 8'(i*4)) begin
							nxt_st.rdata = 32'(st_ff.wt[i*LTP_WW +: LTP_WW]);
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.thr <= LTP_THR_RST;
			st_ff.cnt_lim <= LTP_CNT_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gating decode from the current mode; combinational from st_ff, the outputs themselves not registered
	always_comb begin
		pwr = '1;
		pwr.standby_voltage_req = 1'b0;
		pwr.low_freq_ref_clock_en = 1'b1;
		unique case (st_ff.mode)
			LTP_RUN: begin
			end
			LTP_WAIT: pwr.core_clk_en = 1'b0; // RL10
			LTP_DOZE: begin
				pwr.core_clk_en = 1'b0; // RL11
				pwr.fabric_clk_en = 1'b0; // RL11
			end
			LTP_STOP: begin
				pwr = '0; // RL12
				pwr.main_oscillator_on = ~st_ff.ctrl[LTP_C_OSCOFF]; // RL12
				// Static stop also halts the low-frequency reference
				pwr.low_freq_ref_clock_en = ~st_ff.ctrl[LTP_C_OSCOFF]; // RL14
				// Retention only while the standby voltage bit is set
				pwr.standby_voltage_req = st_ff.ctrl[LTP_C_STANDBY_VOLTAGE_CONTROL]; // RL13 RL16
			end
		endcase
	end
endmodule

// ==== ltp_pkg.sv ====
package ltp_pkg;
	// APB register byte offsets
	localparam logic [7:0] LTP_CTRL_OFS = 8'h00;
	localparam logic [7:0] LTP_THR_OFS = 8'h04;
	localparam logic [7:0] LTP_CNT_OFS = 8'h08;
	localparam logic [7:0] LTP_STAT_OFS = 8'h0c;
	localparam logic [7:0] LTP_LOAD_OFS = 8'h10;
	localparam logic [7:0] LTP_LOG_OFS = 8'h14;
	localparam logic [7:0] LTP_WT_OFS = 8'h40;
	// Control field positions
	localparam int LTP_C_EN = 0;
	localparam int LTP_C_MASK = 1;
	localparam int LTP_C_START = 2;
	localparam int LTP_C_DONE = 3;
	localparam int LTP_C_STANDBY_VOLTAGE_CONTROL = 4;
	localparam int LTP_C_LPM = 5;
	localparam int LTP_C_OSCOFF = 7;
	localparam int LTP_C_DMA = 8;
	localparam int LTP_C_LOGIE = 9;
	// Widths
	localparam int LTP_NLD = 16;
	localparam int LTP_WW = 4;
	localparam int LTP_LW = 10;
	localparam int LTP_AVG_SH = 5;
	localparam int LTP_EMA_SH = 3;
	localparam int LTP_CW = 6;
	localparam int LTP_LOGD = 8;
	// Reset values
	localparam logic [31:0] LTP_THR_RST = 32'h00f0_0040;
	localparam logic [31:0] LTP_CNT_RST = 32'h0000_0404;
	localparam logic [LTP_WW-1:0] LTP_WT_RST = 4'h0;
	// Low power mode codes
	typedef enum logic [1:0] {
		LTP_RUN = 2'h0,
		LTP_WAIT = 2'h1,
		LTP_DOZE = 2'h2,
		LTP_STOP = 2'h3
	} ltp_mode_t;
	// Clock and supply gating outputs
	typedef struct packed {
		logic core_clk_en;
		logic fabric_clk_en;
		logic module_clk_en;
		logic main_pll_on;
		logic peripheral_pll_on;
		logic main_oscillator_on;
		logic audio_osc_on;
		logic per_clk_en;
		logic low_freq_ref_clock_en;
		logic standby_voltage_req;
	} ltp_pwr_t;
endpackage

// ==== ltp_load_track_properties.sv ====
module ltp_load_track_properties
	import ltp_pkg::*;
(
	// APB side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	// Events and power
	input wire logic scale_irq,
	input wire logic scale_dma_req,
	input wire logic wakeup,
	input wire ltp_pwr_t pwr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// One route only, so software never services an event twice
	a_one_route: assert property (!(scale_irq && scale_dma_req))
		else $error("irq and dma event high together");
	a_irq_holds: assert property ($fell(scale_irq) |->
		$past(psel && penable && pwrite && pready && paddr == LTP_CTRL_OFS))
		else $error("irq dropped without a control write");
	a_wait_keeps: assert property (!pwr.core_clk_en && pwr.fabric_clk_en |->
		pwr.main_pll_on && pwr.main_oscillator_on) else $error("wait mode lost pll or osc");
	a_doze_core: assert property (!pwr.fabric_clk_en |-> !pwr.core_clk_en)
		else $error("core clock runs without fabric");
	a_stop_all_off: assert property (!pwr.main_pll_on |-> !(pwr.peripheral_pll_on ||
		pwr.audio_osc_on || pwr.per_clk_en || pwr.module_clk_en || pwr.fabric_clk_en))
		else $error("stop mode left a clock running");
	a_retention_stop: assert property (pwr.standby_voltage_req |-> !pwr.main_pll_on)
		else $error("rail lowered outside stop");
	a_static_stop: assert property (!pwr.main_oscillator_on |->
		!pwr.low_freq_ref_clock_en && !pwr.main_pll_on) else $error("static stop incomplete");
	a_wake_run: assert property (wakeup |=> pwr.core_clk_en && pwr.main_pll_on)
		else $error("wakeup did not restore run");
	c_irq: cover property ($rose(scale_irq));
	c_dma: cover property ($rose(scale_dma_req));
	c_retention: cover property (pwr.standby_voltage_req);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ltp_load_track ltp_load_track_properties ltp_load_track_properties_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .scale_irq(scale_irq), .scale_dma_req(scale_dma_req),
	.wakeup(wakeup), .pwr(pwr));

// ==== ltp_core_model.sv ====
module ltp_core_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Commands from the bench
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic busy_req,
	// Core status towards the block
	output logic wait_for_irq_idle,
	output logic wfi_enter,
	output logic wakeup
);
	timeunit 1ns;
	timeprecision 1ps;
	logic asleep_ff;
	// A sleeping core is idle too, so load tracking sees the real duty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{asleep_ff, wait_for_irq_idle, wfi_enter, wakeup} <= 4'h0;
		end else begin
			wfi_enter <= sleep_req && !asleep_ff;
			wakeup <= wake_req;
			asleep_ff <= (asleep_ff || sleep_req) && !wake_req;
			wait_for_irq_idle <= asleep_ff || !busy_req;
		end
	end
endmodule

// ==== ltp_load_track_test.sv ====
module ltp_load_track_test
	import ltp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, wake_req, busy_req;
	logic wait_for_irq_idle, wfi_enter, wakeup, scale_irq, scale_dma_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [LTP_NLD-1:0] load_in;
	logic [2:0] gate_tbl [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
	ltp_pwr_t pwr;
	int num_errors = 0;
	int n_compared = 0;
	ltp_load_track ltp_load_track_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wait_for_irq_idle(wait_for_irq_idle),
		.load_in(load_in), .scale_irq(scale_irq), .scale_dma_req(scale_dma_req),
		.wfi_enter(wfi_enter), .wakeup(wakeup), .pwr(pwr));
	ltp_core_model ltp_core_model_i (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
		.wake_req(wake_req), .busy_req(busy_req), .wait_for_irq_idle(wait_for_irq_idle),
		.wfi_enter(wfi_enter), .wakeup(wakeup));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// Setup, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		{psel, penable} <= 2'h0;
	endtask
	task automatic sleep_in(input logic [31:0] ctrl);
		apb(1'b1, LTP_CTRL_OFS, ctrl);
		@(posedge pclk) sleep_req <= 1'b1;
		@(posedge pclk) sleep_req <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic test_done;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Watchdog sized well beyond the longest load ramp
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		test_done;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, sleep_req, wake_req} = '0;
		busy_req = 1'b1;
		load_in = 16'h8001;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, LTP_THR_OFS, 32'h0);
		chk("threshold reset", rd, LTP_THR_RST);
		apb(1'b0, LTP_CNT_OFS, 32'h0);
		chk("count reset", rd, LTP_CNT_RST);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped read", rd, 32'h0);
		apb(1'b1, LTP_WT_OFS + 8'h3c, 32'h5);
		apb(1'b0, LTP_WT_OFS + 8'h3c, 32'h0);
		chk("weight 15", rd, 32'h5);
		// Fully busy core gives the top of the window count
		apb(1'b1, LTP_CTRL_OFS, 32'h1);
		repeat (80) @(posedge pclk);
		apb(1'b0, LTP_LOAD_OFS, 32'h0);
		chk("busy cpu load", 32'(rd[9:0]), 32'h200);
		for (int i = 0; i < 4000 && scale_irq !== 1'b1; i++) @(posedge pclk);
		chk("scale irq", 32'(scale_irq), 32'h1);
		apb(1'b0, LTP_STAT_OFS, 32'h0);
		chk("advice up", 32'(rd[1:0]), 32'h1);
		// Service starts with the start flag set and the event masked
		apb(1'b1, LTP_CTRL_OFS, 32'h7);
		// No voltage-compensation register here, so ordering is left to software
		repeat (2) @(posedge pclk);
		chk("masked irq", 32'(scale_irq), 32'h0);
		apb(1'b1, LTP_CTRL_OFS, 32'h101);
		repeat (2) @(posedge pclk);
		chk("dma route", 32'({scale_dma_req, scale_irq}), 32'h2);
		// Idle core drains the average below the lower threshold
		busy_req <= 1'b0;
		apb(1'b1, LTP_CTRL_OFS, 32'h3);
		for (int i = 0; i < 400 && rd[1:0] !== 2'h2; i++) apb(1'b0, LTP_STAT_OFS, 32'h0);
		chk("advice down", 32'(rd[1:0]), 32'h2);
		apb(1'b0, LTP_LOAD_OFS, 32'h0);
		chk("idle cpu load", 32'(rd[9:0]), 32'h0);
		for (int m = 0; m < 5; m++) begin
			sleep_in(m == 4 ? 32'he0 : (32'(m % 4) << 5) | (m == 3 ? 32'h10 : 32'h0));
			chk("gating", 32'({pwr.core_clk_en, pwr.fabric_clk_en, pwr.main_pll_on}),
				32'(gate_tbl[m == 4 ? 3 : m]));
			chk("rail request", 32'(pwr.standby_voltage_req), 32'(m == 3));
			if (m == 4)
				chk("static stop", 32'({pwr.main_oscillator_on, pwr.low_freq_ref_clock_en}),
					32'h0);
			@(posedge pclk) wake_req <= 1'b1;
			@(posedge pclk) wake_req <= 1'b0;
			repeat (3) @(posedge pclk);
			chk("run after wake", 32'(pwr.core_clk_en), 32'h1);
		end
		test_done;
	end
endmodule
